// file: core/srdc_pkg.sv
//------------------------------------------------------------------------------
// srdc_pkg
//------------------------------------------------------------------------------
// Purpose: shared constants of the serial relay driver control block
// Assumes: system clock of 125 MHz
// Notes:   addresses, widths, serial register reset values and the default coil timing count live here
package srdc_pkg;

	// widths of the serial registers
	localparam int ADDR_W  = 16;
	localparam int DATA_W  = 32;
	localparam int RELAYS  = 16;
	localparam int ID_W    = 32;
	localparam int IDCNT_W = 6;

	// register addresses held in the address latch
	localparam logic [ADDR_W-1:0] ADDR_IDENT  = 16'h0000;
	localparam logic [ADDR_W-1:0] ADDR_COIL   = 16'h0001;
	localparam logic [ADDR_W-1:0] ADDR_STATUS = 16'h0002;
	localparam logic [ADDR_W-1:0] ADDR_PARK   = 16'hffff;

	// module identity word, value arbitrary
	localparam logic [ID_W-1:0] MODULE_ID_DEF = 32'h0000_005a;

	// identity bits sent before zeros follow (four bytes)
	localparam logic [IDCNT_W-1:0] ID_BITS = 6'h20;

	// reset values
	localparam logic [ADDR_W-1:0]  ADDR_RST  = 16'h0000;
	localparam logic [DATA_W-1:0]  DATA_RST  = 32'h0000_0000;
	localparam logic [IDCNT_W-1:0] IDCNT_RST = 6'h00;

	// coil drive time, longest time so rounded down
	localparam int CLK_PERIOD_NS = 8;
	localparam int COIL_MAX_MS   = 20;
	localparam int COIL_CYCLES   = (COIL_MAX_MS * 1000000) / CLK_PERIOD_NS;

	// coil driver states
	typedef enum logic [1:0] {
		SRDC_IDLE  = 2'b01,
		SRDC_DRIVE = 2'b10
	} srdc_coil_st_t;

endpackage

// file: core/srdc_sync.sv
//------------------------------------------------------------------------------
// srdc_sync
//------------------------------------------------------------------------------
// Purpose: two flip-flop synchroniser for a group of pin levels
// Assumes: inputs are asynchronous levels
// Notes:   only the second stage is visible outside
`timescale 1ns/10ps
module srdc_sync #(
	parameter int         W   = 1,
	parameter logic [W-1:0] RST = '0
) (
	input  wire logic         clk_sys_i, // system clock
	input  wire logic         srst_i,    // synchronous reset
	input  wire logic [W-1:0] d_i,       // asynchronous levels
	output logic      [W-1:0] q_o        // synchronised levels
);

	logic [W-1:0] meta_r;
	logic [W-1:0] meta_nxt;
	logic [W-1:0] q_nxt;

	// next values of both stages
	always_comb begin
		meta_nxt = d_i;
		q_nxt    = meta_r;
		if (srst_i) begin
			meta_nxt = RST;
			q_nxt    = RST;
		end
	end

	// stage registers
	always_ff @(posedge clk_sys_i) begin
		meta_r <= meta_nxt;
		q_o    <= q_nxt;
	end

endmodule

// file: core/srdc_top.sv
//------------------------------------------------------------------------------
// srdc_top
//------------------------------------------------------------------------------
// Purpose: digital control of a 16-relay latching switch module
// Assumes: serial link pins are asynchronous and sampled by clk_sys_i
// Notes:   open-collector lines are driven low while their enable is high
//
// What this block does
// - idle-high clock, data taken on rising edge
// - serial activity ignored while slot select high
// - module reset pin restores power-up state
// - address latch decodes one target register
// - coil register shifts only when selected
// - slot select or data/address rise latches data
// - coil word undefined until first write
// - reset never energises any coil
// - identity sent four bytes, then zeros
// - one status bit shows switching or done
// - low sixteen bits drive set coils
// - high sixteen bits drive reset coils
// - coils driven bounded time, then released
// - board signals buffered onto backplane lines
// - decode identity, coil, status addresses; park selects nothing
// - identity low byte first, msb first
// - address cleared at reset, msb first
// - status low from switch start to end
`timescale 1ns/10ps
module srdc_top
	import srdc_pkg::*;
#(
	parameter int              COIL_TICKS = srdc_pkg::COIL_CYCLES,
	parameter logic [31:0]     MODULE_ID  = srdc_pkg::MODULE_ID_DEF
) (
	input  wire logic                        clk_sys_i,              // system clock
	input  wire logic                        srst_i,                 // synchronous reset
	input  wire logic                        module_reset_n_i,       // backplane reset pin
	input  wire logic                        slot_select_n_i,        // backplane slot select
	input  wire logic                        serial_clock_i,         // backplane clock level
	output logic                             serial_clock_o,         // backplane clock drive value
	output logic                             serial_clock_oe_o,      // backplane clock pull low
	input  wire logic                        mosi_i,                 // backplane host data level
	output logic                             mosi_o,                 // backplane host data drive value
	output logic                             mosi_oe_o,              // backplane host data pull low
	input  wire logic                        data_not_address_i,     // backplane data/address level
	output logic                             data_not_address_o,     // backplane data/address drive value
	output logic                             data_not_address_oe_o,  // backplane data/address pull low
	output logic                             slot_zero_strobe_n_o,   // backplane strobe drive value
	output logic                             slot_zero_strobe_n_oe_o,// backplane strobe pull low
	input  wire logic                        miso_i,                 // backplane module data level
	output logic                             miso_o,                 // backplane module data drive value
	output logic                             miso_oe_o,              // backplane module data pull low
	input  wire logic                        board_serial_clock_i,   // board clock
	input  wire logic                        board_serial_in_i,      // board data out to modules
	input  wire logic                        board_data_not_address_i, // board data/address
	input  wire logic                        board_slot_zero_strobe_n_i, // board strobe
	output logic                             board_serial_out_o,     // backplane data back to board
	output logic [srdc_pkg::RELAYS-1:0]      set_coil_o,             // set coil drive values
	output logic [srdc_pkg::RELAYS-1:0]      reset_coil_o,           // reset coil drive values
	output logic                             coil_drive_oe_o,        // coil drivers enabled
	output logic                             relays_done_o           // status bit, low while switching
);

	localparam int CNT_W = $clog2(COIL_TICKS + 1);
	localparam logic [CNT_W-1:0] COIL_LOAD = CNT_W'(COIL_TICKS - 1);

	//--------------------------------------------------------------------------
	// pin synchronisers
	//--------------------------------------------------------------------------
	logic [9:0] pin_s;
	logic       sclk_s;
	logic       mosi_s;
	logic       da_s;
	logic       ss_n_s;
	logic       miso_s;
	logic       rst;

	// all pin levels: backplane link, board side, reset pin
	srdc_sync #(.W(10), .RST(10'h3ff)) u_sync_pin (
		.clk_sys_i (clk_sys_i),
		.srst_i    (srst_i),
		.d_i       ({serial_clock_i, mosi_i, data_not_address_i, slot_select_n_i, miso_i, board_serial_clock_i,
		             board_serial_in_i, board_data_not_address_i, board_slot_zero_strobe_n_i, module_reset_n_i}),
		.q_o       (pin_s)
	);

	assign sclk_s = pin_s[9];
	assign mosi_s = pin_s[8];
	assign da_s   = pin_s[7];
	assign ss_n_s = pin_s[6];
	assign miso_s = pin_s[5];

	assign rst = srst_i | ~pin_s[0];

	//--------------------------------------------------------------------------
	// edge detection
	//--------------------------------------------------------------------------
	logic sclk_d_r;
	logic da_d_r;
	logic ss_n_d_r;
	logic sclk_rise;
	logic da_rise;
	logic ss_rise;

	// previous levels of the synchronised lines
	always_ff @(posedge clk_sys_i) begin
		sclk_d_r <= rst ? 1'b1 : sclk_s;
		da_d_r   <= rst ? 1'b1 : da_s;
		ss_n_d_r <= rst ? 1'b1 : ss_n_s;
	end

	// second edge of an idle-high clock
	assign sclk_rise = sclk_s & ~sclk_d_r;
	assign da_rise   = da_s & ~da_d_r;
	assign ss_rise   = ss_n_s & ~ss_n_d_r;

	//--------------------------------------------------------------------------
	// serial registers
	//--------------------------------------------------------------------------
	logic [ADDR_W-1:0]  addr_r;
	logic [ADDR_W-1:0]  addr_nxt;
	logic [DATA_W-1:0]  data_r;
	logic [DATA_W-1:0]  data_nxt;
	logic               dirty_r;
	logic               dirty_nxt;
	logic [IDCNT_W-1:0] id_cnt_r;
	logic [IDCNT_W-1:0] id_cnt_nxt;
	logic               link_on;
	logic               sel_ident;
	logic               sel_coil;
	logic               sel_status;
	logic               latch;

	// link active only while slot select low
	assign link_on = ~ss_n_s;
	// park and reserved addresses select nothing
	assign sel_ident  = (addr_r == ADDR_IDENT);
	assign sel_coil   = (addr_r == ADDR_COIL);
	assign sel_status = (addr_r == ADDR_STATUS);

	// rise of data/address or slot select latches
	assign latch = dirty_r & (ss_rise | (link_on & da_rise));

	// next values of address, coil word and identity position
	always_comb begin
		addr_nxt   = addr_r;
		data_nxt   = data_r;
		dirty_nxt  = dirty_r;
		id_cnt_nxt = id_cnt_r;
		if (link_on && sclk_rise) begin
			if (da_s) begin
				addr_nxt = {addr_r[ADDR_W-2:0], mosi_s};
			end else if (sel_coil) begin
				// first bit ends at bit 31
				data_nxt  = {data_r[DATA_W-2:0], mosi_s};
				dirty_nxt = 1'b1;
			end else if (sel_ident && id_cnt_r != ID_BITS) begin
				id_cnt_nxt = id_cnt_r + 6'h01;
			end
		end
		if (latch) begin
			dirty_nxt = 1'b0;
		end
		if (!(link_on && !da_s && sel_ident)) begin
			id_cnt_nxt = IDCNT_RST;
		end
	end

	// coil word content has no meaning before a write
	always_ff @(posedge clk_sys_i) begin
		if (rst) begin
			addr_r   <= ADDR_RST;
			data_r   <= DATA_RST;
			dirty_r  <= 1'b0;
			id_cnt_r <= IDCNT_RST;
		end else begin
			addr_r   <= addr_nxt;
			data_r   <= data_nxt;
			dirty_r  <= dirty_nxt;
			id_cnt_r <= id_cnt_nxt;
		end
	end

	//--------------------------------------------------------------------------
	// coil driver timing
	//--------------------------------------------------------------------------
	srdc_coil_st_t     st_r;
	srdc_coil_st_t     st_nxt;
	logic [CNT_W-1:0]  tick_r;
	logic [CNT_W-1:0]  tick_nxt;
	logic [RELAYS-1:0] set_r;
	logic [RELAYS-1:0] set_nxt;
	logic [RELAYS-1:0] rset_r;
	logic [RELAYS-1:0] rset_nxt;
	logic              oe_r;
	logic              oe_nxt;
	logic              done_r;
	logic              done_nxt;

	// next coil state, counter and drive values
	always_comb begin
		st_nxt   = st_r;
		tick_nxt = tick_r;
		set_nxt  = set_r;
		rset_nxt = rset_r;
		oe_nxt   = oe_r;
		done_nxt = done_r;
		case (st_r)
			SRDC_IDLE: begin
				set_nxt  = '0;
				rset_nxt = '0;
				oe_nxt   = 1'b0;
				done_nxt = 1'b1;
			end
			SRDC_DRIVE: begin
				if (tick_r == '0) begin
					st_nxt   = SRDC_IDLE;
					set_nxt  = '0;
					rset_nxt = '0;
					oe_nxt   = 1'b0;
					done_nxt = 1'b1;
				end else begin
					tick_nxt = tick_r - CNT_W'(1);
				end
			end
			default: begin
				st_nxt   = SRDC_IDLE;
				oe_nxt   = 1'b0;
				done_nxt = 1'b1;
			end
		endcase
		if (latch) begin
			// counter starts on the latching edge
			st_nxt   = SRDC_DRIVE;
			tick_nxt = COIL_LOAD;
			set_nxt  = data_r[RELAYS-1:0];
			rset_nxt = data_r[DATA_W-1:RELAYS];
			oe_nxt   = 1'b1;
			done_nxt = 1'b0;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (rst) begin
			st_r   <= SRDC_IDLE;
			tick_r <= '0;
			set_r  <= '0;
			rset_r <= '0;
			oe_r   <= 1'b0;
			done_r <= 1'b1;
		end else begin
			st_r   <= st_nxt;
			tick_r <= tick_nxt;
			set_r  <= set_nxt;
			rset_r <= rset_nxt;
			oe_r   <= oe_nxt;
			done_r <= done_nxt;
		end
	end

	//--------------------------------------------------------------------------
	// read data and line buffering
	//--------------------------------------------------------------------------
	logic       id_bit;
	logic       miso_oe_nxt;
	logic [3:0] bp_oe_r;
	logic       miso_oe_r;
	logic       board_out_r;

	// byte index from high bits, bit order reversed
	assign id_bit = (id_cnt_r < ID_BITS) ? MODULE_ID[{id_cnt_r[4:3], ~id_cnt_r[2:0]}] : 1'b0;

	// open-collector read line pulls low for a zero
	always_comb begin
		miso_oe_nxt = 1'b0;
		if (link_on && !da_s) begin
			if (sel_ident) begin
				miso_oe_nxt = ~id_bit;
			end else if (sel_status) begin
				miso_oe_nxt = ~done_r;
			end
		end
	end

	// board lines repeated onto the backplane
	always_ff @(posedge clk_sys_i) begin
		if (rst) begin
			bp_oe_r     <= 4'h0;
			miso_oe_r   <= 1'b0;
			board_out_r <= 1'b1;
		end else begin
			bp_oe_r     <= ~pin_s[4:1];
			miso_oe_r   <= miso_oe_nxt;
			board_out_r <= miso_s;
		end
	end

	// host strobe passes through to slot zero
	assign slot_zero_strobe_n_oe_o = bp_oe_r[0];
	assign slot_zero_strobe_n_o    = 1'b0;
	assign serial_clock_oe_o       = bp_oe_r[3];
	assign serial_clock_o          = 1'b0;
	assign mosi_oe_o               = bp_oe_r[2];
	assign mosi_o                  = 1'b0;
	assign data_not_address_oe_o   = bp_oe_r[1];
	assign data_not_address_o      = 1'b0;
	assign miso_oe_o               = miso_oe_r;
	assign miso_o                  = 1'b0;
	assign board_serial_out_o      = board_out_r;
	assign set_coil_o              = set_r;
	assign reset_coil_o            = rset_r;
	assign coil_drive_oe_o         = oe_r;
	assign relays_done_o           = done_r;

endmodule

// file: verif/srdc_monitor.sv
// Purpose: port checker of the relay control block
// Assumes: bound to srdc_top, one clock domain
// Notes:   checks except a_rst pause while either reset is active
`timescale 1ns/10ps
module srdc_monitor
	import srdc_pkg::*;
#(
	parameter int COIL_TICKS = 1000
) (
	input wire logic              clk_sys_i, // clock
	input wire logic              srst_i, // reset
	input wire logic              module_reset_n_i, // pin reset
	input wire logic              slot_select_n_i, // select
	input wire logic              data_not_address_i, // d/a wire
	input wire logic              serial_clock_oe_o, // clock pull
	input wire logic              mosi_oe_o, // data pull
	input wire logic              data_not_address_oe_o, // d/a pull
	input wire logic              slot_zero_strobe_n_oe_o, // strobe pull
	input wire logic              miso_oe_o, // read pull
	input wire logic              board_serial_clock_i, // board clock
	input wire logic              board_serial_in_i, // board data
	input wire logic              board_data_not_address_i, // board d/a
	input wire logic              board_slot_zero_strobe_n_i, // board strobe
	input wire logic [RELAYS-1:0] set_coil_o, // set coils
	input wire logic [RELAYS-1:0] reset_coil_o, // reset coils
	input wire logic              coil_drive_oe_o, // coil enable
	input wire logic              relays_done_o // status
);
	int cnt_r;
	int cnt_nxt;
	// cycles of coil drive so far
	always_comb begin
		cnt_nxt = coil_drive_oe_o ? cnt_r + 1 : 0;
	end
	always_ff @(posedge clk_sys_i) begin
		cnt_r <= srst_i ? 0 : cnt_nxt;
	end
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (srst_i || !module_reset_n_i);
	property p_idle; !coil_drive_oe_o |-> set_coil_o == '0 && reset_coil_o == '0; endproperty
	a_idle: assert property (p_idle) else $error("coil value while released");
	property p_done; relays_done_o != coil_drive_oe_o; endproperty
	a_done: assert property (p_done) else $error("status disagrees with drive");
	property p_len; $fell(coil_drive_oe_o) |-> cnt_r == COIL_TICKS; endproperty
	a_len: assert property (p_len) else $error("coil drive length wrong");
	property p_rst; disable iff (1'b0) srst_i |=> !coil_drive_oe_o && relays_done_o; endproperty
	a_rst: assert property (p_rst) else $error("coil driven in reset");
	property p_ss; slot_select_n_i [*8] |-> !miso_oe_o; endproperty
	a_ss: assert property (p_ss) else $error("read line pulled while deselected");
	property p_latch; $rose(coil_drive_oe_o) |-> slot_select_n_i || data_not_address_i; endproperty
	a_latch: assert property (p_latch) else $error("coil drive without release");
	property p_bufa; serial_clock_oe_o == !$past(board_serial_clock_i, 3)
		&& mosi_oe_o == !$past(board_serial_in_i, 3); endproperty
	a_bufa: assert property (p_bufa) else $error("clock or data buffer wrong");
	property p_bufb; data_not_address_oe_o == !$past(board_data_not_address_i, 3)
		&& slot_zero_strobe_n_oe_o == !$past(board_slot_zero_strobe_n_i, 3); endproperty
	a_bufb: assert property (p_bufb) else $error("d/a or strobe buffer wrong");
endmodule

// file: verif/srdc_host.sv
// Purpose: host side of the serial link
// Assumes: link half period of ten system clocks
// Notes:   released lines float high
`timescale 1ns/10ps
module srdc_host (
	input  wire logic clk_sys_i, // clock
	input  wire logic miso_i, // read wire
	output logic      sclk_o, // link clock
	output logic      mosi_o, // host data
	output logic      dna_o, // data/address
	output logic      ss_n_o // slot select
);
	logic [39:0] rd_r;
	// idle levels of the link
	initial begin
		sclk_o = 1'b1;
		mosi_o = 1'b1;
		dna_o = 1'b1;
		ss_n_o = 1'b1;
		rd_r = '0;
	end
	task automatic wt(input int n);
		repeat (n) @(negedge clk_sys_i);
	endtask
	task automatic sel(input logic s_n, input logic d);
		ss_n_o = s_n;
		dna_o = d;
	endtask
	task automatic shift(input logic [39:0] v, input int n);
		for (int i = n - 1; i >= 0; i--) begin
			sclk_o = 1'b0;
			mosi_o = v[i];
			wt(10);
			rd_r = {rd_r[38:0], miso_i};
			sclk_o = 1'b1;
			wt(10);
		end
		mosi_o = 1'b1;
	endtask
	task automatic xfer(input logic s, input logic [15:0] a, input logic [39:0] v, input int n);
		sel(!s, 1'b1);
		wt(10);
		shift({24'h0, a}, 16);
		dna_o = 1'b0;
		wt(10);
		shift(v, n);
	endtask
	task automatic stop();
		sel(1'b1, 1'b1);
		wt(10);
	endtask
endmodule

// file: verif/srdc_top_tb.sv
// Purpose: self-checking bench of the relay control block
// Assumes: host model drives the backplane link
// Notes:   coil drive shortened to CT clocks
`timescale 1ns/10ps
module srdc_top_tb;
	import srdc_pkg::*;
	localparam int          CT = 1000;
	localparam logic [31:0] ID = 32'h1234_a53c; // arbitrary value
	logic                   clk_sys_i, srst_i, module_reset_n_i, miso_pu, sck, mo, da, ss_n;
	logic                   board_serial_clock_i, board_serial_in_i, board_data_not_address_i;
	logic                   board_slot_zero_strobe_n_i, board_serial_out_o, coil_drive_oe_o, relays_done_o;
	logic                   serial_clock_o, mosi_o, data_not_address_o, slot_zero_strobe_n_o, miso_o;
	logic                   serial_clock_oe_o, mosi_oe_o, data_not_address_oe_o, slot_zero_strobe_n_oe_o, miso_oe_o;
	logic [RELAYS-1:0]      set_coil_o, reset_coil_o;
	int                     n_mismatch = 0, n_tests = 0, cyc = 0;
	// open-collector wires pulled high; slot select driven directly by the host
	wire logic              slot_select_n_i = ss_n;
	wire logic              serial_clock_i = sck & ~serial_clock_oe_o;
	wire logic              mosi_i = mo & ~mosi_oe_o;
	wire logic              data_not_address_i = da & ~data_not_address_oe_o;
	wire logic              miso_i = miso_pu & ~miso_oe_o;

	srdc_top #(.COIL_TICKS(CT), .MODULE_ID(ID)) dut_u (.*);
	srdc_host host_u (.clk_sys_i, .miso_i, .sclk_o(sck), .mosi_o(mo), .dna_o(da), .ss_n_o(ss_n));

	// clock and hang limit
	initial begin
		clk_sys_i = 1'b0;
		forever #4 clk_sys_i = ~clk_sys_i;
	end
	always @(posedge clk_sys_i) begin
		cyc++;
		if (cyc == 40000) begin
			n_mismatch++;
			finish_test();
		end
	end

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			n_mismatch++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic brd(input logic [3:0] v);
		board_serial_clock_i       = v[3];
		board_serial_in_i          = v[2];
		board_data_not_address_i   = v[1];
		board_slot_zero_strobe_n_i = v[0];
	endtask
	task automatic wait_oe(input logic v);
		for (int i = 0; i < CT + 100 && coil_drive_oe_o !== v; i++) @(negedge clk_sys_i);
		chk("coil drive", v, coil_drive_oe_o);
	endtask
	task automatic t_reset();
		chk("idle state", 3'b011, {coil_drive_oe_o, relays_done_o, board_serial_out_o});
		chk("coils", '0, {set_coil_o, reset_coil_o});
	endtask
	task automatic t_ident();
		logic [39:0] e;
		for (int k = 0; k < 40; k++) e[39-k] = (k < 32) ? ID[8*(k/8)+7-k%8] : 1'b0;
		host_u.xfer(1'b1, 16'h0000, '0, 40);
		host_u.stop();
		chk("ident", e[39:8], host_u.rd_r[39:8]);
		chk("ident tail", e[7:0], host_u.rd_r[7:0]);
	endtask
	task automatic t_write(input logic [31:0] w, input logic via_ss);
		host_u.xfer(1'b1, 16'h0001, {8'h00, w}, 32);
		if (via_ss) begin
			host_u.stop();
		end else begin
			host_u.xfer(1'b1, 16'h0002, '0, 0);
		end
		wait_oe(1'b1);
		chk("set coils", w[15:0], set_coil_o);
		chk("reset coils", w[31:16], reset_coil_o);
		chk("status busy", via_ss, miso_i);
		wait_oe(1'b0);
		host_u.wt(6);
		chk("status done", 1'b1, miso_i);
		chk("coils off", '0, {set_coil_o, reset_coil_o});
		host_u.stop();
	endtask
	task automatic t_ignore();
		logic [15:0] a [3] = '{16'h0001, 16'h0005, 16'hffff};
		for (int i = 0; i < 3; i++) begin
			host_u.xfer(i != 0, a[i], 40'hff_ffff_0000, 32);
			host_u.stop();
			chk("no drive", 1'b0, coil_drive_oe_o);
			chk("read idle", 32'hffff_ffff, host_u.rd_r[31:0]);
		end
	endtask
	task automatic t_buf();
		brd(4'h5);
		miso_pu = 1'b0;
		host_u.wt(4);
		chk("buffer pattern 5", 5'h14, {serial_clock_oe_o, mosi_oe_o, data_not_address_oe_o,
			slot_zero_strobe_n_oe_o, board_serial_out_o});
		chk("drive values", 5'h00, {serial_clock_o, mosi_o, data_not_address_o,
			slot_zero_strobe_n_o, miso_o});
		brd(4'ha);
		miso_pu = 1'b1;
		host_u.wt(4);
		chk("buffer pattern a", 5'h0b, {serial_clock_oe_o, mosi_oe_o, data_not_address_oe_o,
			slot_zero_strobe_n_oe_o, board_serial_out_o});
		brd(4'hf);
		host_u.wt(4);
		chk("buffer high", 5'h01, {serial_clock_oe_o, mosi_oe_o, data_not_address_oe_o,
			slot_zero_strobe_n_oe_o, board_serial_out_o});
	endtask
	task automatic t_pin();
		host_u.xfer(1'b1, 16'h0001, 40'h80, 32);
		host_u.stop();
		wait_oe(1'b1);
		module_reset_n_i = 1'b0;
		host_u.wt(5);
		module_reset_n_i = 1'b1;
		host_u.wt(5);
		chk("pin reset", 3'b011, {coil_drive_oe_o, relays_done_o, board_serial_out_o});
		host_u.sel(1'b0, 1'b0);
		host_u.wt(8);
		chk("address cleared", ID[7], miso_i);
		host_u.stop();
	endtask
	task automatic finish_test();
		$display("checks %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	// main sequence, words never set both coils of a relay
	initial begin
		srst_i = 1'b1;
		module_reset_n_i = 1'b1;
		miso_pu = 1'b1;
		brd(4'hf);
		repeat (3) @(negedge clk_sys_i);
		srst_i = 1'b0;
		host_u.wt(5);
		t_reset();
		t_ident();
		t_ident();
		t_write(32'h830f_0000, 1'b0);
		t_write(32'h0000_00f1, 1'b1);
		t_write(32'h0102_0a00, 1'b0);
		t_ignore();
		t_buf();
		t_pin();
		finish_test();
	end
endmodule

bind srdc_top srdc_monitor #(.COIL_TICKS(COIL_TICKS)) mon_u (.*);
